// ==== term_osc_pkg.sv ====
// Constants and types for the termination and oscillator run-time mode registers
//
// Functional notes
// - Three-bit controller termination value, 000 disables
// - Bit 3 set disables clock termination
// - Bit 4 set disables chip-select termination
// - Bit 5 set disables command/address termination
// - Writes and reads touch write-selected set point
// - Operation uses only the operating set point
// - Strap pin ignored; strength and register decide
// - Byte-mode bits choose which lanes terminate
// - Run-time register at 17H, write only
// - Nonzero run time stops timer after 16N clocks
// - Stop command stops timer when run time zero
// - Termination register answers at address 16H
package term_osc_pkg;

	// ----------------------------------------------------------------
	// Addresses and codes
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_TERMINATION_CONTROL = 6'h16;
	localparam logic [5:0] ADDR_DQS_OSC_RUN_TIME    = 6'h17;
	localparam logic [6:0] MPC_STOP_OSCILLATOR      = 7'h4D;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int        CTRL_VAL_LSB          = 0;
	localparam int        CK_DIS_BIT            = 3;
	localparam int        CS_DIS_BIT            = 4;
	localparam int        CA_DIS_BIT            = 5;
	localparam int        LANE_SEL_LSB          = 6;
	localparam logic [7:0] TERM_RESET           = 8'h00;
	localparam logic [7:0] RUN_TIME_RESET       = 8'h00;
	localparam logic [2:0] STRENGTH_OFF         = 3'h0;
	localparam logic [2:0] CTRL_VAL_RESERVED    = 3'h7;

	// Byte-lane select codes
	localparam logic [1:0] LANES_BOTH           = 2'h0;
	localparam logic [1:0] LANES_UPPER_ONLY     = 2'h1;
	localparam logic [1:0] LANES_LOWER_ONLY     = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLOCKS_PER_RUN_STEP  = 16;
	localparam int         OSC_CNT_W            = 12;
	localparam logic [OSC_CNT_W-1:0] OSC_CNT_ZERO = 12'h000;
	localparam logic [OSC_CNT_W-1:0] OSC_CNT_ONE  = 12'h001;

	// Stored layout of one set point of the termination register
	typedef struct packed {
		logic [1:0] byte_lane_termination_select;
		logic       cmd_addr_termination_disable;
		logic       chip_select_termination_disable;
		logic       clock_termination_disable;
		logic [2:0] controller_termination_value;
	} term_fields_t;

	// Termination enables per signal group and byte lane
	typedef struct packed {
		logic ca_lower;
		logic ca_upper;
		logic cs_lower;
		logic cs_upper;
		logic ck_lower;
		logic ck_upper;
	} term_enables_t;

endpackage

// ==== term_osc_regs.sv ====
// Termination control and DQS oscillator run-time mode registers
`timescale 1ns/1ps
`default_nettype none

module term_osc_regs (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire logic                        mr_write,
	input  wire logic                        mr_read,
	input  wire logic [5:0]                  mr_addr,
	input  wire logic [7:0]                  mr_wdata,
	output logic [7:0]                       mr_rdata,
	output logic                             mr_rdata_valid,
	input  wire logic                        mpc_valid,
	input  wire logic [6:0]                  mpc_op,
	input  wire logic                        write_set_point_select,
	input  wire logic                        operating_set_point_select,
	input  wire logic [2:0]                  termination_strength,
	input  wire logic                        io_config_bit0,
	input  wire logic                        termination_strap_pin,
	input  wire logic                        osc_start,
	output logic [2:0]                       controller_termination_value,
	output term_osc_pkg::term_enables_t      term_enables,
	output logic                             osc_running,
	output logic                             osc_stop
);

	// ----------------------------------------------------------------
	// Set-point storage
	// ----------------------------------------------------------------
	term_osc_pkg::term_fields_t set_point_q [2];
	term_osc_pkg::term_fields_t set_point_d [2];
	logic [7:0]                 run_time_q;
	logic [7:0]                 run_time_d;
	logic                       term_hit;
	logic                       run_hit;

	assign term_hit = (mr_addr == term_osc_pkg::ADDR_TERMINATION_CONTROL);
	assign run_hit  = (mr_addr == term_osc_pkg::ADDR_DQS_OSC_RUN_TIME);

	// Each copy takes a write only when the write select points at it
	genvar sp;
	generate
		for (sp = 0; sp < 2; sp++) begin : g_set_point
			always_comb begin
				set_point_d[sp] = set_point_q[sp];
				if (mr_write && term_hit && (write_set_point_select == sp[0])) begin
					set_point_d[sp] = term_osc_pkg::term_fields_t'(mr_wdata);
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					set_point_q[sp] <= term_osc_pkg::term_fields_t'(term_osc_pkg::TERM_RESET);
				end else begin
					set_point_q[sp] <= set_point_d[sp];
				end
			end
		end
	endgenerate

	// Run-time register is written at its own address only
	always_comb begin
		run_time_d = run_time_q;
		if (mr_write && run_hit) begin
			run_time_d = mr_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			run_time_q <= term_osc_pkg::RUN_TIME_RESET;
		end else begin
			run_time_q <= run_time_d;
		end
	end

	// ----------------------------------------------------------------
	// Mode-register read path
	// ----------------------------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	// Run time is write only, so it and unmapped addresses read as zero
	always_comb begin
		rvalid_d = mr_read;
		rdata_d  = 8'h00;
		if (mr_read && term_hit) begin
			rdata_d = set_point_q[write_set_point_select];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign mr_rdata       = rdata_q;
	assign mr_rdata_valid = rvalid_q;

	// ----------------------------------------------------------------
	// Termination decode from the operating set point
	// ----------------------------------------------------------------
	term_osc_pkg::term_fields_t active;
	term_osc_pkg::term_enables_t enables_d;
	term_osc_pkg::term_enables_t enables_q;
	logic [2:0]                  ctrl_val_d;
	logic [2:0]                  ctrl_val_q;
	logic                        lower_ok;
	logic                        upper_ok;
	logic                        strap_unused;

	// Strap pin is deliberately dropped; boards tie it to a rail
	assign strap_unused = termination_strap_pin;
	assign active       = set_point_q[operating_set_point_select];

	always_comb begin
		lower_ok = 1'b0;
		upper_ok = 1'b0;
		unique case (active.byte_lane_termination_select)
			term_osc_pkg::LANES_BOTH: begin
				lower_ok = 1'b1;
				upper_ok = 1'b1;
			end
			term_osc_pkg::LANES_UPPER_ONLY: begin
				upper_ok = 1'b1;
			end
			term_osc_pkg::LANES_LOWER_ONLY: begin
				lower_ok = 1'b1;
			end
			default: begin
				// Reserved code: neither lane terminates, the safe choice
				lower_ok = 1'b0;
				upper_ok = 1'b0;
			end
		endcase
		if (termination_strength == term_osc_pkg::STRENGTH_OFF) begin
			lower_ok = 1'b0;
			upper_ok = 1'b0;
		end
		enables_d.ck_lower = lower_ok && !active.clock_termination_disable;
		enables_d.ck_upper = upper_ok && !active.clock_termination_disable;
		enables_d.cs_lower = lower_ok && !active.chip_select_termination_disable;
		enables_d.cs_upper = upper_ok && !active.chip_select_termination_disable;
		enables_d.ca_lower = lower_ok && !active.cmd_addr_termination_disable;
		enables_d.ca_upper = upper_ok && !active.cmd_addr_termination_disable;
		// Reserved code is not passed on; treated as disabled
		ctrl_val_d = active.controller_termination_value;
		if (ctrl_val_d == term_osc_pkg::CTRL_VAL_RESERVED) begin
			ctrl_val_d = 3'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			enables_q  <= '0;
			ctrl_val_q <= 3'h0;
		end else begin
			enables_q  <= enables_d;
			ctrl_val_q <= ctrl_val_d;
		end
	end

	assign term_enables                 = enables_q;
	assign controller_termination_value = ctrl_val_q;

	// ----------------------------------------------------------------
	// DQS interval timer run control
	// ----------------------------------------------------------------
	typedef enum logic {OSC_IDLE, OSC_RUN} osc_state_t;

	osc_state_t             state_q;
	osc_state_t             state_d;
	logic [term_osc_pkg::OSC_CNT_W-1:0] cnt_q;
	logic [term_osc_pkg::OSC_CNT_W-1:0] cnt_d;
	logic [term_osc_pkg::OSC_CNT_W-1:0] limit;
	logic                   stop_q;
	logic                   stop_d;
	logic                   mpc_stop;
	logic                   io_unused;

	// Host keeps odd divisors legal itself; input only recorded
	assign io_unused = io_config_bit0;
	// 16 clocks per run-time step; largest code fits in twelve bits
	assign limit    = term_osc_pkg::OSC_CNT_W'({run_time_q, 4'h0});
	assign mpc_stop = mpc_valid && (mpc_op == term_osc_pkg::MPC_STOP_OSCILLATOR)
	                  && (run_time_q == 8'h00);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		stop_d  = 1'b0;
		unique case (state_q)
			OSC_IDLE: begin
				if (osc_start) begin
					state_d = OSC_RUN;
					cnt_d   = term_osc_pkg::OSC_CNT_ONE;
				end
			end
			OSC_RUN: begin
				cnt_d = cnt_q + term_osc_pkg::OSC_CNT_ONE;
				if (run_time_q != 8'h00 && cnt_q == limit) begin
					state_d = OSC_IDLE;
					stop_d  = 1'b1;
				end else if (mpc_stop) begin
					state_d = OSC_IDLE;
					stop_d  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_q <= OSC_IDLE;
			cnt_q   <= term_osc_pkg::OSC_CNT_ZERO;
			stop_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			stop_q  <= stop_d;
		end
	end

	assign osc_running = (state_q == OSC_RUN);
	assign osc_stop    = stop_q;

endmodule

`default_nettype wire

// ==== term_osc_regs_properties.sv ====
// Concurrent checks on the termination and oscillator register ports
`timescale 1ns/1ps
`default_nettype none
module term_osc_checker (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       mr_write,
	input wire logic       mr_read,
	input wire logic [5:0] mr_addr,
	input wire logic [7:0] mr_wdata,
	input wire logic [7:0] mr_rdata,
	input wire logic       mr_rdata_valid,
	input wire logic       mpc_valid,
	input wire logic [6:0] mpc_op,
	input wire logic [2:0] termination_strength,
	input wire logic       osc_start,
	input wire logic [2:0] controller_termination_value,
	input wire term_osc_pkg::term_enables_t term_enables,
	input wire logic       osc_running,
	input wire logic       osc_stop
);
	// ----------------------------------------
	// Run-time shadow
	// ----------------------------------------
	logic [7:0] rt_q;
	logic [7:0] rt_d;
	// The stop rules hinge on the write-only code, so track it from writes
	always_comb begin
		rt_d = (mr_write && mr_addr == 6'h17) ? mr_wdata : rt_q;
	end
	always_ff @(posedge clk_sys) begin
		rt_q <= rstn ? rt_d : 8'h00;
	end
	// Length of the current run in sampled cycles; a counter instead of a long repetition
	logic [11:0] run_len_q;
	always_ff @(posedge clk_sys) begin
		run_len_q <= (rstn && osc_running) ? run_len_q + 12'h001 : 12'h000;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rd_valid; mr_read |=> mr_rdata_valid; endproperty
	property p_wo; mr_read && mr_addr == 6'h17 |=> mr_rdata == 8'h00; endproperty
	property p_reserved; controller_termination_value != 3'h7; endproperty
	property p_off; termination_strength == 3'h0 ##1 termination_strength == 3'h0 |-> term_enables == 6'h00; endproperty
	property p_auto; osc_stop && rt_q != 8'h00 |-> run_len_q == {rt_q, 4'h0}; endproperty
	property p_auto_max; osc_running && rt_q != 8'h00 |-> run_len_q < {rt_q, 4'h0}; endproperty
	property p_mpc; osc_running && mpc_valid && mpc_op == 7'h4D && rt_q == 8'h00 |=> osc_stop && !osc_running; endproperty
	property p_stop_end; osc_stop |-> $past(osc_running) && !osc_running; endproperty
	property p_start; osc_start && !osc_running |=> osc_running; endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read without valid");
	a_wo: assert property (p_wo) else $error("run time readable");
	a_reserved: assert property (p_reserved) else $error("reserved value driven");
	a_off: assert property (p_off) else $error("terminated with zero strength");
	a_auto: assert property (p_auto) else $error("automatic stop not after 16N clocks");
	a_auto_max: assert property (p_auto_max) else $error("timer ran past 16N clocks");
	a_mpc: assert property (p_mpc) else $error("stop command ignored");
	a_stop_end: assert property (p_stop_end) else $error("stop pulse without run end");
	a_start: assert property (p_start) else $error("timer did not start");
	c_stop: cover property (osc_stop);
	c_read: cover property (mr_rdata_valid);
	c_term: cover property (term_enables == 6'h3F);
endmodule
`default_nettype wire

// ==== host_model.sv ====
// Host controller model issuing mode-register and multi-purpose commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic  clk_sys,
	input wire logic  [7:0] mr_rdata,
	output logic      mr_write,
	output logic      mr_read,
	output logic [5:0] mr_addr,
	output logic [7:0] mr_wdata,
	output logic      mpc_valid,
	output logic [6:0] mpc_op
);
	// Idle command bus from time zero
	initial begin
		mr_write = 1'b0;
		mr_read = 1'b0;
		mr_addr = 6'h00;
		mr_wdata = 8'h00;
		mpc_valid = 1'b0;
		mpc_op = 7'h00;
	end
	// One write or read; released lines show the inverse so stale values never pass
	task cmd(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		mr_write <= w;
		mr_read <= !w;
		mr_addr <= a;
		mr_wdata <= d;
		@(posedge clk_sys);
		mr_write <= 1'b0;
		mr_read <= 1'b0;
		mr_addr <= ~a;
		mr_wdata <= ~d;
		#1 q = mr_rdata;
	endtask
	// Stop command; callers issue it only with run time zero
	task stop_osc;
		@(posedge clk_sys);
		mpc_valid <= 1'b1;
		mpc_op <= 7'h4D;
		@(posedge clk_sys);
		mpc_valid <= 1'b0;
		mpc_op <= 7'h32;
		#1;
	endtask
endmodule
`default_nettype wire

// ==== dram_odt_and_dqs_timer_mode_regs_bench.sv ====
// Self-checking bench for the termination and oscillator mode registers
`timescale 1ns/1ps
`default_nettype none
module dram_odt_and_dqs_timer_mode_regs_bench;
	logic clk_sys, rstn, wsel, opsel, strap, osc_start, mr_write, mr_read, mpc_valid, osc_running, osc_stop, vld;
	logic [2:0] strength, ctv;
	logic [5:0] mr_addr;
	logic [6:0] mpc_op;
	logic [7:0] mr_wdata, mr_rdata, q, v;
	term_osc_pkg::term_enables_t en;
	int n_mismatch, num_checks, i, n;
	// ----------------------------------------
	// Clock, design and host
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	term_osc_regs uut (.clk_sys(clk_sys), .rstn(rstn), .mr_write(mr_write), .mr_read(mr_read), .mr_addr(mr_addr),
		.mr_wdata(mr_wdata), .mr_rdata(mr_rdata), .mr_rdata_valid(vld), .mpc_valid(mpc_valid), .mpc_op(mpc_op),
		.write_set_point_select(wsel), .operating_set_point_select(opsel), .termination_strength(strength),
		.io_config_bit0(1'b1), .termination_strap_pin(strap), .osc_start(osc_start),
		.controller_termination_value(ctv), .term_enables(en), .osc_running(osc_running), .osc_stop(osc_stop));
	host_model hm (.clk_sys(clk_sys), .mr_rdata(mr_rdata), .mr_write(mr_write), .mr_read(mr_read),
		.mr_addr(mr_addr), .mr_wdata(mr_wdata), .mpc_valid(mpc_valid), .mpc_op(mpc_op));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Expected enables {ca_lo,ca_up,cs_lo,cs_up,ck_lo,ck_up}; lane code 3 lets no lane through
	function logic [5:0] exp_en(input logic [7:0] r, input logic [2:0] s);
		logic up, lo;
		up = r[7:6] == 2'h0 || r[7:6] == 2'h1;
		lo = r[7:6] == 2'h0 || r[7:6] == 2'h2;
		return (s == 3'h0) ? 6'h00 : {!r[5] && lo, !r[5] && up, !r[4] && lo, !r[4] && up, !r[3] && lo, !r[3] && up};
	endfunction
	task settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task t_access;
		hm.cmd(1'b1, 6'h16, 8'h00, q);
		@(posedge clk_sys) strength <= 3'h4;
		settle;
		chk({2'h0, en}, 8'h3F);
		hm.cmd(1'b1, 6'h17, 8'h05, q);
		hm.cmd(1'b0, 6'h17, 8'h00, q);
		chk(q, 8'h00);
		chk({7'h0, vld}, 8'h01);
		hm.cmd(1'b0, 6'h20, 8'h00, q);
		chk(q, 8'h00);
		$display("access test done");
	endtask
	task t_fields;
		for (i = 0; i < 32; i++) begin
			v = {i[4:0], i[2:0]};
			hm.cmd(1'b1, 6'h16, v, q);
			@(posedge clk_sys) strap <= ~strap;
			settle;
			chk({2'h0, en}, {2'h0, exp_en(v, strength)});
			chk({5'h0, ctv}, {5'h0, (v[2:0] == 3'h7) ? 3'h0 : v[2:0]});
			hm.cmd(1'b0, 6'h16, 8'h00, q);
			chk(q, v);
		end
		$display("field test done");
	endtask
	task t_setpoint;
		hm.cmd(1'b1, 6'h16, 8'h00, q);
		@(posedge clk_sys) wsel <= 1'b1;
		hm.cmd(1'b1, 6'h16, 8'h38, q);
		settle;
		chk({2'h0, en}, 8'h3F);
		hm.cmd(1'b0, 6'h16, 8'h00, q);
		chk(q, 8'h38);
		@(posedge clk_sys) wsel <= 1'b0;
		hm.cmd(1'b0, 6'h16, 8'h00, q);
		chk(q, 8'h00);
		@(posedge clk_sys) strength <= 3'h0;
		settle;
		chk({2'h0, en}, 8'h00);
		@(posedge clk_sys) strength <= 3'h4;
		@(posedge clk_sys) opsel <= 1'b1;
		settle;
		chk({2'h0, en}, 8'h00);
		$display("set point test done");
	endtask
	task t_timer;
		for (i = 1; i < 3; i++) begin
			hm.cmd(1'b1, 6'h17, i[7:0], q);
			@(posedge clk_sys) osc_start <= 1'b1;
			@(posedge clk_sys) osc_start <= 1'b0;
			#1 n = 0;
			while (osc_running && n < 600) begin
				n++;
				@(posedge clk_sys);
				#1;
			end
			chk(n[7:0], 8'h10 * i[7:0]);
			chk({7'h0, osc_stop}, 8'h01);
		end
		hm.cmd(1'b1, 6'h17, 8'h00, q);
		@(posedge clk_sys) osc_start <= 1'b1;
		@(posedge clk_sys) osc_start <= 1'b0;
		repeat (40) @(posedge clk_sys);
		#1 chk({7'h0, osc_running}, 8'h01);
		hm.stop_osc;
		chk({6'h0, osc_stop, osc_running}, 8'h02);
		$display("timer test done");
	endtask
	// Main sequence: reset held twelve cycles, then each scenario
	initial begin
		rstn = 1'b0;
		wsel = 1'b0;
		opsel = 1'b0;
		strap = 1'b0;
		strength = 3'h0;
		osc_start = 1'b0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_access;
		t_fields;
		t_setpoint;
		t_timer;
		results;
	end
	// Scenarios need about four hundred cycles; this limit is far beyond that
	initial begin
		#100000;
		n_mismatch++;
		results;
	end
endmodule
bind term_osc_regs term_osc_checker chk_i (.clk_sys(clk_sys), .rstn(rstn), .mr_write(mr_write), .mr_read(mr_read),
	.mr_addr(mr_addr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata), .mr_rdata_valid(mr_rdata_valid),
	.mpc_valid(mpc_valid), .mpc_op(mpc_op), .termination_strength(termination_strength), .osc_start(osc_start),
	.controller_termination_value(controller_termination_value), .term_enables(term_enables),
	.osc_running(osc_running), .osc_stop(osc_stop));
`default_nettype wire
